// [inc/btm_pkg.sv]
// Constants shared by the boost, thermal and misc control register bank.
package btm_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] BTM_ADDR_BOOST_THERMAL = 8'h06;
    localparam logic [7:0] BTM_ADDR_MISC          = 8'h07;
    localparam logic [7:0] BTM_BOOST_THERMAL_RST  = 8'h93;
    localparam logic [7:0] BTM_MISC_RST           = 8'h4B;
    localparam logic [7:0] BTM_UNMAPPED_READ      = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BTM_BOOST_OUT_VOLTAGE_CODE_LSB    = 4;
    localparam int BTM_BHOT_LSB      = 2;
    localparam int BTM_DIE_THERMAL_REG_SELECT_LSB      = 0;
    localparam int BTM_FORCE_DET_BIT = 7;
    localparam int BTM_TMR_HALF_BIT  = 6;
    localparam int BTM_BAT_SW_BIT    = 5;
    localparam int BTM_MASK_CHG_BIT  = 1;
    localparam int BTM_MASK_BAT_BIT  = 0;

    // ****************************************************************
    // Field meanings
    // ****************************************************************
    localparam logic [12:0] BTM_BOOST_BASE_MV  = 13'h11C6;
    localparam logic [12:0] BTM_BOOST_STEP_MV  = 13'h0040;
    localparam logic [1:0]  BTM_BHOT_DISABLED  = 2'h3;
    localparam logic [6:0]  BTM_LEVEL_MID_PCT  = 7'h21;
    localparam logic [6:0]  BTM_LEVEL_HIGH_PCT = 7'h24;
    localparam logic [6:0]  BTM_LEVEL_LOW_PCT  = 7'h1E;
    localparam logic [6:0]  BTM_DIE_THERMAL_REG_SELECT_BASE_C    = 7'h3C;
    localparam logic [6:0]  BTM_DIE_THERMAL_REG_SELECT_STEP_C    = 7'h14;

    // Selected boost cutoff level in percent of the regulator rail.
    function automatic logic [6:0] btm_level_pct(input logic [1:0] code);
        logic [6:0] level;
        level = BTM_LEVEL_MID_PCT;
        unique case (code)
            2'h0: level = BTM_LEVEL_MID_PCT;
            2'h1: level = BTM_LEVEL_HIGH_PCT;
            2'h2: level = BTM_LEVEL_LOW_PCT;
            2'h3: level = BTM_LEVEL_MID_PCT;
        endcase
        return level;
    endfunction : btm_level_pct

endpackage : btm_pkg

// [logic/btm_boost_guard.sv]
// Boost mode thermistor guard: cutoff and thermistor fault from the sense level.
`timescale 1ns/1ps
`default_nettype none
module btm_boost_guard
    import btm_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Settings and sense
    input  wire logic [1:0] bhot_code_i,
    input  wire logic       boost_mode_i,
    input  wire logic [6:0] ntc_sense_pct_i,
    // Results
    output logic            boost_cutoff_o,
    output logic            thermistor_fault_o
);

    logic       cutoff_reg;
    logic       cutoff_next;
    logic       fault_reg;
    logic       fault_next;
    logic       below;

    // ****************************************************************
    // Threshold compare
    // ****************************************************************
    // A hotter battery pulls the sense voltage lower, so below is hot.
    always_comb
    begin
        below       = ntc_sense_pct_i < btm_level_pct(bhot_code_i);
        cutoff_next = boost_mode_i && below && (bhot_code_i != BTM_BHOT_DISABLED);
        fault_next  = boost_mode_i && below;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cutoff_reg <= 1'b0;
            fault_reg  <= 1'b0;
        end
        else
        begin
            cutoff_reg <= cutoff_next;
            fault_reg  <= fault_next;
        end
    end

    assign boost_cutoff_o     = cutoff_reg;
    assign thermistor_fault_o = fault_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    boost_cutoff_a: assert property (
        boost_mode_i && bhot_code_i == 2'h1 && ntc_sense_pct_i < 7'h24 |=> boost_cutoff_o)
        else $error("Boost not cut off below the selected level.");
    no_cutoff_disabled_a: assert property (
        bhot_code_i == 2'h3 |=> !boost_cutoff_o)
        else $error("Boost cut off while protection is disabled.");
    fault_mid_level_a: assert property (
        boost_mode_i && bhot_code_i == 2'h3 |=> thermistor_fault_o == ($past(ntc_sense_pct_i) < 7'h21))
        else $error("Thermistor fault not on the mid level.");

endmodule : btm_boost_guard
`default_nettype wire

// [logic/btm_control_regs.sv]
// Boost voltage, thermal regulation and misc operation control registers.
//
// Notes on behaviour
// - Boost output voltage is 4.55 V plus 512/256/128/64 mV per code bit, code resets to 1001.
// - Boost cutoff code 00, 01, 10 selects 33%, 36%, 30% of the regulator rail, reset 00.
// - In boost mode the boost is cut off when the thermistor sense crosses the selected level.
// - Code 11 keeps boost running, yet the thermistor fault still uses the 33% level.
// - Thermal regulation code 00..11 selects 60, 80, 100, 120 degrees C, reset 11.
// - All eight misc bits are read/write and reset to 0x4B.
// - Misc bits are detect force 7, timer half speed 6, switch off 5, reserved 4..2, masks 1..0.
// - Writing 1 to detect force with input power starts detection; the bit clears when done.
// - With the half speed bit set, the safety timer runs at half rate during limiting or regulation.
// - Switch off bit 1 turns the battery switch off; 0 allows it on.
// - Interrupt on charge fault only with mask bit 1 set, on battery fault only with bit 0 set.
`timescale 1ns/1ps
`default_nettype none
module btm_control_regs
    import btm_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Register port from the serial bus engine
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wr_data_i,
    output logic [7:0]       reg_rd_data_o,
    output logic             reg_rd_valid_o,
    // Power path and charger status
    input  wire logic        input_power_good_i,
    input  wire logic        detect_done_i,
    input  wire logic        boost_mode_i,
    input  wire logic [6:0]  ntc_sense_pct_i,
    input  wire logic        input_limiting_i,
    input  wire logic        thermal_regulating_i,
    input  wire logic        timer_tick_i,
    input  wire logic        charge_fault_i,
    input  wire logic        battery_fault_i,
    // Controls to the analog side
    output logic [3:0]       boost_out_voltage_code_o,
    output logic [12:0]      boost_out_mv_o,
    output logic [1:0]       die_thermal_reg_select_o,
    output logic [6:0]       die_thermal_limit_c_o,
    output logic             boost_cutoff_o,
    output logic             thermistor_fault_o,
    output logic             detect_start_o,
    output logic             safety_timer_tick_o,
    output logic             battery_switch_off_o,
    output logic             int_request_o
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0]  boost_thermal_reg;
    logic [7:0]  boost_thermal_next;
    logic [7:0]  misc_reg;
    logic [7:0]  misc_next;
    logic        detect_busy_reg;
    logic        detect_busy_next;
    logic        half_phase_reg;
    logic        half_phase_next;
    logic [12:0] boost_mv_reg;
    logic [12:0] boost_mv_next;
    logic [6:0]  die_thermal_reg_select_c_reg;
    logic [6:0]  die_thermal_reg_select_c_next;
    logic        int_reg;
    logic        int_next;
    logic [7:0]  rd_data_reg;
    logic [7:0]  rd_data_next;
    logic        rd_valid_reg;
    logic        rd_valid_next;
    logic        wr_misc;
    logic        set_detect;
    logic        slow_active;

    function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                            input logic [7:0] boost_voltage_thermal_control,
                                            input logic [7:0] misc_operation_control);
        logic [7:0] data;
        data = BTM_UNMAPPED_READ;
        if (addr == BTM_ADDR_BOOST_THERMAL)
            data = boost_voltage_thermal_control;
        else if (addr == BTM_ADDR_MISC)
            data = misc_operation_control;
        return data;
    endfunction : read_mux

    // ****************************************************************
    // Register writes and self clearing detect force
    // ****************************************************************
    always_comb
    begin
        wr_misc    = reg_wr_i && (reg_addr_i == BTM_ADDR_MISC);
        set_detect = wr_misc && reg_wr_data_i[BTM_FORCE_DET_BIT];
        boost_thermal_next = boost_thermal_reg;
        if (reg_wr_i && reg_addr_i == BTM_ADDR_BOOST_THERMAL)
            boost_thermal_next = reg_wr_data_i;
        misc_next = misc_reg;
        if (wr_misc)
            misc_next = reg_wr_data_i;
        // A fresh write of 1 wins over completion in the same cycle.
        if (detect_busy_reg && detect_done_i && !set_detect)
            misc_next[BTM_FORCE_DET_BIT] = 1'b0;
        detect_busy_next = detect_busy_reg;
        if (detect_start_o)
            detect_busy_next = 1'b1;
        else if (detect_done_i)
            detect_busy_next = 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            boost_thermal_reg <= BTM_BOOST_THERMAL_RST;
            misc_reg          <= BTM_MISC_RST;
            detect_busy_reg   <= 1'b0;
        end
        else
        begin
            boost_thermal_reg <= boost_thermal_next;
            misc_reg          <= misc_next;
            detect_busy_reg   <= detect_busy_next;
        end
    end

    // Detection is started once per request and only with input power.
    assign detect_start_o = misc_reg[BTM_FORCE_DET_BIT] && input_power_good_i
                            && !detect_busy_reg;

    // ****************************************************************
    // Decoded controls, timer rate and interrupt
    // ****************************************************************
    always_comb
    begin
        boost_mv_next = BTM_BOOST_BASE_MV + BTM_BOOST_STEP_MV
                        * {9'h000, boost_thermal_reg[BTM_BOOST_OUT_VOLTAGE_CODE_LSB +: 4]};
        die_thermal_reg_select_c_next   = BTM_DIE_THERMAL_REG_SELECT_BASE_C + BTM_DIE_THERMAL_REG_SELECT_STEP_C
                        * {5'h00, boost_thermal_reg[BTM_DIE_THERMAL_REG_SELECT_LSB +: 2]};
        slow_active   = misc_reg[BTM_TMR_HALF_BIT]
                        && (input_limiting_i || thermal_regulating_i);
        half_phase_next = 1'b0;
        if (slow_active)
            half_phase_next = timer_tick_i ? !half_phase_reg : half_phase_reg;
        int_next = (charge_fault_i && misc_reg[BTM_MASK_CHG_BIT])
                   || (battery_fault_i && misc_reg[BTM_MASK_BAT_BIT]);
        rd_valid_next = reg_rd_i;
        rd_data_next  = reg_rd_i ? read_mux(reg_addr_i, boost_thermal_reg, misc_reg)
                                 : rd_data_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            boost_mv_reg   <= 13'h0000;
            die_thermal_reg_select_c_reg     <= 7'h00;
            half_phase_reg <= 1'b0;
            int_reg        <= 1'b0;
            rd_data_reg    <= 8'h00;
            rd_valid_reg   <= 1'b0;
        end
        else
        begin
            boost_mv_reg   <= boost_mv_next;
            die_thermal_reg_select_c_reg     <= die_thermal_reg_select_c_next;
            half_phase_reg <= half_phase_next;
            int_reg        <= int_next;
            rd_data_reg    <= rd_data_next;
            rd_valid_reg   <= rd_valid_next;
        end
    end

    // Every second base tick is passed while the timer is slowed.
    assign safety_timer_tick_o = timer_tick_i && (!slow_active || half_phase_reg);

    assign boost_out_voltage_code_o = boost_thermal_reg[BTM_BOOST_OUT_VOLTAGE_CODE_LSB +: 4];
    assign die_thermal_reg_select_o = boost_thermal_reg[BTM_DIE_THERMAL_REG_SELECT_LSB +: 2];
    assign boost_out_mv_o           = boost_mv_reg;
    assign die_thermal_limit_c_o    = die_thermal_reg_select_c_reg;
    assign battery_switch_off_o     = misc_reg[BTM_BAT_SW_BIT];
    assign int_request_o            = int_reg;
    assign reg_rd_data_o            = rd_data_reg;
    assign reg_rd_valid_o           = rd_valid_reg;

    // ****************************************************************
    // Boost thermistor guard
    // ****************************************************************
    btm_boost_guard u_guard (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .bhot_code_i        (boost_thermal_reg[BTM_BHOT_LSB +: 2]),
        .boost_mode_i       (boost_mode_i),
        .ntc_sense_pct_i    (ntc_sense_pct_i),
        .boost_cutoff_o     (boost_cutoff_o),
        .thermistor_fault_o (thermistor_fault_o)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence detect_done_s;
        detect_busy_reg && detect_done_i && !set_detect;
    endsequence

    sequence detect_start_s;
        detect_start_o ##1 detect_busy_reg;
    endsequence

    // A passed tick, two idle cycles, then the next tick while still slowed.
    sequence slow_tick_gap_s;
        slow_active && safety_timer_tick_o ##1 (slow_active && !timer_tick_i)[*2]
        ##1 (slow_active && timer_tick_i);
    endsequence

    reset_values_a: assert property (
        $fell(rst_i) |-> boost_thermal_reg == 8'h93 && misc_reg == 8'h4B)
        else $error("Wrong register values after reset.");
    boost_mv_value_a: assert property (
        !$past(rst_i) |-> boost_out_mv_o
            == 13'h11C6 + 13'h0040 * {9'h000, $past(boost_out_voltage_code_o)})
        else $error("Boost millivolts do not match the code.");
    die_thermal_reg_select_limit_value_a: assert property (
        !$past(rst_i) |-> die_thermal_limit_c_o
            == 7'h3C + 7'h14 * {5'h00, $past(die_thermal_reg_select_o)})
        else $error("Thermal limit does not match the code.");
    misc_write_a: assert property (
        wr_misc |=> misc_reg[6:0] == $past(reg_wr_data_i[6:0]))
        else $error("Misc register write not stored.");
    switch_off_a: assert property (
        wr_misc |=> battery_switch_off_o == $past(reg_wr_data_i[5]))
        else $error("Battery switch control not at bit 5.");
    int_mask_a: assert property (
        charge_fault_i && !misc_reg[1] && !(battery_fault_i && misc_reg[0]) |=> !int_request_o)
        else $error("Interrupt raised on a masked charge fault.");
    detect_clear_a: assert property (
        detect_start_s ##[0:20] detect_done_s |=> !misc_reg[7])
        else $error("Detect force bit not cleared after detection.");
    detect_power_a: assert property (
        detect_start_o |-> input_power_good_i ##1 !detect_start_o)
        else $error("Detection started without power or repeated.");
    half_rate_a: assert property (
        slow_tick_gap_s |-> !safety_timer_tick_o)
        else $error("Safety timer not halved.");
    full_rate_a: assert property (
        timer_tick_i && !misc_reg[6] |-> safety_timer_tick_o)
        else $error("Safety timer slowed while half speed is off.");
    read_back_a: assert property (
        reg_rd_i && reg_addr_i == 8'h07 |=> reg_rd_valid_o && reg_rd_data_o == $past(misc_reg))
        else $error("Misc register read back wrong.");

endmodule : btm_control_regs
`default_nettype wire

// [testbench/btm_host_model.sv]
// Host model that issues single byte writes and reads on the register strobe port.
`timescale 1ns/1ps
`default_nettype none
module btm_host_model
    import btm_pkg::*;
(
    // Clock
    input  wire logic       clk_i,
    // Register strobes
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wr_data_o
);
    initial
    begin
        reg_wr_o      = 1'b0;
        reg_rd_o      = 1'b0;
        reg_addr_o    = 8'hFF;
        reg_wr_data_o = 8'hFF;
    end

    // Released lines show the inverse of the last value so stale data is never read back.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        #1;
        reg_addr_o    = addr;
        reg_wr_data_o = (addr == BTM_ADDR_MISC) ? ((data & 8'hE3) | 8'h08) : data;
        reg_wr_o      = 1'b1;
        @(posedge clk_i);
        #1;
        reg_wr_o      = 1'b0;
        reg_addr_o    = ~addr;
        reg_wr_data_o = ~reg_wr_data_o;
    endtask : wr

    task automatic rd(input logic [7:0] addr);
        @(posedge clk_i);
        #1;
        reg_addr_o = addr;
        reg_rd_o   = 1'b1;
        @(posedge clk_i);
        #1;
        reg_rd_o   = 1'b0;
        reg_addr_o = ~addr;
    endtask : rd
endmodule : btm_host_model
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the boost, thermal and misc control registers.
`timescale 1ns/1ps
`default_nettype none
module tb
    import btm_pkg::*;
;
    logic clk, rst, wr_s, rd_s, pg, done, boost, lim, die_thermal_reg_select_act, tick, cf, bf;
    logic [7:0] addr, wdata, rd_data, d;
    logic rd_valid, cutoff, tfault, dstart, stick, swoff, irq;
    logic [6:0] sense, limc;
    logic [3:0] vcode;
    logic [1:0] tsel;
    logic [12:0] mv;
    logic [6:0] lvl [4] = '{7'h21, 7'h24, 7'h1E, 7'h21};
    logic [7:0] exp_q [$];
    int n_mismatch = 0;
    int checks = 0;
    int n_start = 0;
    int n_tick = 0;

    btm_host_model btm_host_model_i (.clk_i(clk), .reg_wr_o(wr_s), .reg_rd_o(rd_s),
        .reg_addr_o(addr), .reg_wr_data_o(wdata));

    btm_control_regs btm_control_regs_i (.clk_i(clk), .rst_i(rst), .reg_wr_i(wr_s),
        .reg_rd_i(rd_s), .reg_addr_i(addr), .reg_wr_data_i(wdata), .reg_rd_data_o(rd_data),
        .reg_rd_valid_o(rd_valid), .input_power_good_i(pg), .detect_done_i(done),
        .boost_mode_i(boost), .ntc_sense_pct_i(sense), .input_limiting_i(lim),
        .thermal_regulating_i(die_thermal_reg_select_act), .timer_tick_i(tick), .charge_fault_i(cf),
        .battery_fault_i(bf), .boost_out_voltage_code_o(vcode), .boost_out_mv_o(mv),
        .die_thermal_reg_select_o(tsel), .die_thermal_limit_c_o(limc),
        .boost_cutoff_o(cutoff), .thermistor_fault_o(tfault), .detect_start_o(dstart),
        .safety_timer_tick_o(stick), .battery_switch_off_o(swoff), .int_request_o(irq));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        btm_host_model_i.rd(a);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Read data and output pulses are taken at the falling edge where they are settled.
    always @(negedge clk)
    begin
        if (rd_valid === 1'b1)
        begin
            if (exp_q.size() > 0)
                chk("read data", {5'h00, exp_q.pop_front()}, {5'h00, rd_data});
            else
            begin
                n_mismatch++;
                $display("ERROR read data expected none seen %0h", rd_data);
            end
        end
        if (dstart === 1'b1) n_start++;
        if (stick === 1'b1) n_tick++;
    end

    initial
    begin
        #50000;
        n_mismatch++;
        $display("ERROR watchdog expected finish seen timeout");
        results();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial
    begin
        {rst, pg, done, boost, lim, die_thermal_reg_select_act, tick, cf, bf} = 9'h100;
        sense = 7'h64;
        void'($urandom(32'h0B99));
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        cyc(2);
        chk("boost mv", 13'h1406, mv);
        chk("thermal limit", 13'h0078, {6'h00, limc});
        chk("switch off", 13'h0000, {12'h000, swoff});
        rd(BTM_ADDR_BOOST_THERMAL, 8'h93);
        rd(BTM_ADDR_MISC, 8'h4B);
        rd(8'h3C, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            d = {i[3:0], 2'h0, 2'($urandom)};
            btm_host_model_i.wr(BTM_ADDR_BOOST_THERMAL, d);
            cyc(1);
            chk("boost code", {9'h000, i[3:0]}, {9'h000, vcode});
            chk("boost mv", 13'h11C6 + 13'(i) * 13'h0040, mv);
            chk("thermal select", {11'h000, d[1:0]}, {11'h000, tsel});
            chk("thermal limit", 13'h003C + 13'(d[1:0]) * 13'h0014, {6'h00, limc});
            rd(BTM_ADDR_BOOST_THERMAL, d);
        end
        boost = 1'b1;
        for (int c = 0; c < 4; c++)
            for (int k = 0; k < 2; k++)
            begin
                btm_host_model_i.wr(BTM_ADDR_BOOST_THERMAL, {4'h9, c[1:0], 2'h3});
                sense = (k == 0) ? lvl[c] - 7'h01 : lvl[c];
                cyc(2);
                chk("boost cutoff", {12'h000, (c != 3 && k == 0)}, {12'h000, cutoff});
                chk("thermistor fault", {12'h000, (k == 0)}, {12'h000, tfault});
            end
        boost = 1'b0;
        sense = 7'h64;
        for (int m = 0; m < 16; m++)
        begin
            d = {2'h0, m[0], 3'h2, m[1:0]};
            btm_host_model_i.wr(BTM_ADDR_MISC, d);
            {cf, bf} = m[3:2];
            cyc(2);
            chk("interrupt", {12'h000, (m[3] & m[1]) | (m[2] & m[0])}, {12'h000, irq});
            chk("switch off", {12'h000, m[0]}, {12'h000, swoff});
            rd(BTM_ADDR_MISC, d);
        end
        for (int s = 0; s < 3; s++)
        begin
            btm_host_model_i.wr(BTM_ADDR_MISC, {1'b0, (s != 0), 6'h0B});
            lim = (s == 1);
            die_thermal_reg_select_act = (s == 2);
            n_tick = 0;
            repeat (4)
            begin
                tick = 1'b1;
                cyc(1);
                tick = 1'b0;
                cyc(2);
            end
            chk("timer ticks", (s == 0) ? 13'h0004 : 13'h0002, 13'(n_tick));
        end
        btm_host_model_i.wr(BTM_ADDR_MISC, 8'h8B);
        n_start = 0;
        cyc(4);
        chk("detect starts", 13'h0000, 13'(n_start));
        rd(BTM_ADDR_MISC, 8'h8B);
        pg = 1'b1;
        cyc(3);
        chk("detect starts", 13'h0001, 13'(n_start));
        done = 1'b1;
        cyc(1);
        done = 1'b0;
        cyc(2);
        rd(BTM_ADDR_MISC, 8'h0B);
        cyc(3);
        results();
    end
endmodule : tb
`default_nettype wire
